// file: src/ars_regs.vh
// register map and timing constants of the reclose sequencer
`ifndef ARS_REGS_VH
`define ARS_REGS_VH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define ARS_OFF_CTRL        8'h00
`define ARS_OFF_DEAD1       8'h04
`define ARS_OFF_DEAD2       8'h08
`define ARS_OFF_ACT1        8'h0C
`define ARS_OFF_ACT2        8'h10
`define ARS_OFF_RECLAIM     8'h14
`define ARS_OFF_EXTLIM      8'h18
`define ARS_OFF_STATUS      8'h1C

// ------------------------------------------------------------------
// control and status fields
// ------------------------------------------------------------------
`define ARS_CTRL_EN         0
`define ARS_CTRL_EXT        1
`define ARS_CTRL_FOLLOW     2
`define ARS_CTRL_SHOTS_LO   4
`define ARS_CTRL_SHOTS_HI   7
`define ARS_ST_STATE_LO     0
`define ARS_ST_STATE_HI     2
`define ARS_ST_SHOT_LO      4
`define ARS_ST_SHOT_HI      7
`define ARS_ST_CLOSE        8
`define ARS_ST_BLOCKED      9
`define ARS_ST_FINAL        10
`define ARS_ST_SUCCESS      11

// ------------------------------------------------------------------
// reset values, counts and timing (ticks of 1 ms)
// ------------------------------------------------------------------
`define ARS_RST_CTRL        8'h11
`define ARS_RST_DEAD1       16'h01F4
`define ARS_RST_DEAD2       16'h03E8
`define ARS_RST_ACT1        16'h0064
`define ARS_RST_ACT2        16'h0064
`define ARS_RST_RECLAIM     16'h0BB8
`define ARS_RST_EXTLIM      16'h0BB8
`define ARS_MAX_SHOTS       4'h8
`define ARS_ONE_SHOT        4'h1
`define ARS_CLK_NS          10
`define ARS_TICK_NS         1000000
`define ARS_BLOCK_MS        500
`define ARS_NS_PER_MS       1000000

`endif

// file: src/ars_tick_gen.v
// one-cycle tick enable divided from the system clock
module ars_tick_gen #(
    parameter integer DIV = 100000,   // clock cycles per tick
    parameter integer CW  = 17        // counter width, must hold DIV-1
) (
    input  wire clk,                  // system clock
    input  wire rstn,                 // synchronous reset, active low
    output reg  tick                  // one-cycle pulse every DIV cycles
);
    localparam integer LAST = DIV - 1;

    reg [CW-1:0] cnt_q;

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            cnt_q <= {CW{1'b0}};
            tick  <= 1'b0;
        end
        else if (cnt_q == LAST[CW-1:0])
        begin
            cnt_q <= {CW{1'b0}};
            tick  <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
            tick  <= 1'b0;
        end
    end
endmodule

// file: src/ars_seq.v
// multi-shot reclose sequencer with a Wishbone register slave
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`include "ars_regs.vh"

// Operation
// RULE1: trip in reclaim is final unless more cycles are permitted.
// RULE2: after a final trip, enter dynamic blocking and refuse new starts.
// RULE3: reclose attempts per fault are configurable, up to eight.
// RULE4: cycles one and two have own action time, dead time and block input.
// RULE5: cycles three onward reuse the cycle two settings and block input.
// RULE6: failed attempt below the maximum starts the next cycle instead of blocking.
// RULE7: dead time starts when trip drops or breaker contacts show open.
// RULE8: at dead time end, close the breaker and start reclaim together.
// RULE9: each new trip clears reclaim; the next close restarts it.
// RULE10: reclaim expiring without trip is success; return to idle.
// RULE11: when all permitted cycles fail, final trip then dynamic blocking.
// RULE12: extension supervision starts when dead time ends with close withheld.
// RULE13: extension supervision expiry blocks dynamically for 500 ms.
// RULE14: after blocking, return to idle only if no other block condition.
// RULE15: external relay drives general pickup and trip-for-reclose inputs.
// RULE16: externally, trip drives the sequence; pickup only starts action timers.
// RULE17: a setting selects whether external control follows pickup or trip.
// RULE18: external relay with dependent zones adds zone inputs. The module has no zone inputs.
// RULE19: dynamic blocking refuses restarts for 0.5 s, then returns to idle.
// RULE20: no start while breaker contacts show the breaker not closed.
// RULE21: all timers count a common periodic tick from the system clock.
// RULE22: reset gives idle, cleared cycle count, stopped timers, close low.
module ars_seq #(
    parameter integer TICK_DIV = `ARS_TICK_NS / `ARS_CLK_NS, // cycles per timer tick
    parameter integer TW       = 16                          // timer width in bits
) (
    input  wire        clk,                         // 100 MHz system clock
    input  wire        rstn,                        // synchronous reset, active low
    input  wire        wb_cyc_i,                    // wishbone cycle
    input  wire        wb_stb_i,                    // wishbone strobe
    input  wire        wb_we_i,                     // wishbone write enable
    input  wire [7:0]  wb_adr_i,                    // wishbone byte address
    input  wire [3:0]  wb_sel_i,                    // wishbone byte lanes
    input  wire [31:0] wb_dat_i,                    // wishbone write data
    output reg  [31:0] wb_dat_o,                    // wishbone read data
    output reg         wb_ack_o,                    // wishbone acknowledge
    input  wire        int_pickup_in,               // internal protection pickup
    input  wire        int_trip_in,                 // internal protection trip
    input  wire        external_general_pickup_in,  // external relay general pickup
    input  wire        external_trip_for_reclose_in,// external relay trip for reclose
    input  wire        cb_aux_closed_in,            // breaker contact: closed
    input  wire        cb_aux_open_in,              // breaker contact: open
    input  wire        block_cycle1_in,             // blocks reclose cycle one
    input  wire        block_cycle2_in,             // blocks cycle two and later
    input  wire        sync_release_in,             // synchro-check permits close
    output reg         close_cmd_o,                 // close command to breaker
    output reg         final_trip_o,                // final trip, level held until blocking ends; stays low when extension expiry blocks
    output reg         blocked_o                    // dynamic blocking active
);
    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [2:0] S_IDLE    = 3'h0;
    localparam [2:0] S_ACTION  = 3'h1;
    localparam [2:0] S_OPENING = 3'h2;
    localparam [2:0] S_DEAD    = 3'h3;
    localparam [2:0] S_EXTEND  = 3'h4;
    localparam [2:0] S_RECLAIM = 3'h5;
    localparam [2:0] S_BLOCKED = 3'h6;

    localparam integer NIN = 9;
    localparam integer  BLOCK_N     =
        (`ARS_BLOCK_MS * `ARS_NS_PER_MS) / `ARS_TICK_NS;            // [RULE13] [RULE19]
    localparam [TW-1:0] BLOCK_TICKS = BLOCK_N[TW-1:0];

    // ------------------------------------------------------------------
    // tick and input synchronisers
    // ------------------------------------------------------------------
    wire tick;

    ars_tick_gen #(
        .DIV (TICK_DIV),
        .CW  (17)
    ) u_tick (
        .clk  (clk),
        .rstn (rstn),
        .tick (tick)
    );                                                              // [RULE21]

    wire [NIN-1:0] pin_raw = {sync_release_in, block_cycle2_in, block_cycle1_in,
                              cb_aux_open_in, cb_aux_closed_in,
                              external_trip_for_reclose_in, external_general_pickup_in,
                              int_trip_in, int_pickup_in};
    wire [NIN-1:0] pin_s;

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi = gi + 1)
        begin : g_sync
            reg m_q;
            reg s_q;
            always @(posedge clk)
            begin
                if (!rstn)
                begin
                    m_q <= 1'b0;
                    s_q <= 1'b0;
                end
                else
                begin
                    m_q <= pin_raw[gi];
                    s_q <= m_q;
                end
            end
            assign pin_s[gi] = s_q;
        end
    endgenerate

    wire int_pu_s  = pin_s[0];
    wire int_tr_s  = pin_s[1];
    wire ext_pu_s  = pin_s[2];
    wire ext_tr_s  = pin_s[3];
    wire cb_cl_s   = pin_s[4];
    wire cb_op_s   = pin_s[5];
    wire blk1_s    = pin_s[6];
    wire blk2_s    = pin_s[7];
    wire sync_ok_s = pin_s[8];

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg [7:0]    ctrl_q;
    reg [TW-1:0] dead1_q;
    reg [TW-1:0] dead2_q;
    reg [TW-1:0] act1_q;
    reg [TW-1:0] act2_q;
    reg [TW-1:0] reclaim_q;
    reg [TW-1:0] extlim_q;
    reg          success_q;

    wire       en_cfg     = ctrl_q[`ARS_CTRL_EN];
    wire       ext_mode   = ctrl_q[`ARS_CTRL_EXT];
    wire       follow_tr  = ctrl_q[`ARS_CTRL_FOLLOW];
    wire [3:0] shots_cfg  = ctrl_q[`ARS_CTRL_SHOTS_HI:`ARS_CTRL_SHOTS_LO];

    // zero means one shot, above eight clamps
    wire [3:0] max_shots = (shots_cfg == 4'h0) ? `ARS_ONE_SHOT :
                           (shots_cfg > `ARS_MAX_SHOTS) ? `ARS_MAX_SHOTS :
                           shots_cfg;                               // [RULE3]

    // external mode follows trip or pickup, per the follow bit
    wire pickup = ext_mode ? ext_pu_s : int_pu_s;                  // [RULE16]
    wire trip   = ext_mode ? (follow_tr ? ext_tr_s : ext_pu_s)
                           : int_tr_s;                              // [RULE17] [RULE15]

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    reg [2:0]    state_q;
    reg [3:0]    shot_q;
    reg [TW-1:0] timer_q;

    wire timer_done = (timer_q == {TW{1'b0}});
    wire first      = (shot_q == 4'h0);

    // cycle one has own settings; later cycles use cycle two's
    wire          cyc_blk = first ? blk1_s  : blk2_s;              // [RULE4] [RULE5]
    wire [TW-1:0] cyc_act = first ? act1_q  : act2_q;              // [RULE4] [RULE5]
    wire [TW-1:0] cyc_dead = (shot_q == `ARS_ONE_SHOT) ? dead1_q : dead2_q;
    wire          more    = (shot_q < max_shots);
    wire          other_block = trip || !en_cfg;

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            state_q      <= S_IDLE;                                 // [RULE22]
            shot_q       <= 4'h0;
            timer_q      <= {TW{1'b0}};
            close_cmd_o  <= 1'b0;
            final_trip_o <= 1'b0;
            blocked_o    <= 1'b0;
            success_q    <= 1'b0;
        end
        else
        begin
            if (tick && !timer_done)
                timer_q <= timer_q - {{(TW-1){1'b0}}, 1'b1};        // [RULE21]
            // close ends once the breaker reports closed
            if (close_cmd_o && cb_cl_s)
                close_cmd_o <= 1'b0;
            case (state_q)
                S_IDLE:
                begin
                    shot_q <= 4'h0;
                    if (en_cfg && cb_cl_s && !cb_op_s)              // [RULE20]
                    begin
                        if (trip)
                        begin
                            success_q <= 1'b0;
                            if (cyc_blk)
                            begin
                                state_q      <= S_BLOCKED;          // [RULE2]
                                final_trip_o <= 1'b1;
                                blocked_o    <= 1'b1;
                                timer_q      <= BLOCK_TICKS;
                            end
                            else
                            begin
                                state_q <= S_OPENING;
                                shot_q  <= `ARS_ONE_SHOT;
                            end
                        end
                        else if (pickup)
                        begin
                            state_q <= S_ACTION;                    // [RULE16]
                            timer_q <= cyc_act;
                        end
                    end
                end
                S_ACTION:
                begin
                    if (trip && !cyc_blk && more)
                    begin
                        state_q <= S_OPENING;
                        shot_q  <= shot_q + 4'h1;
                    end
                    else if (trip || (timer_done && pickup))
                    begin
                        // late trip, blocked or no cycle left: no reclose
                        state_q      <= S_BLOCKED;                  // [RULE2]
                        final_trip_o <= 1'b1;
                        blocked_o    <= 1'b1;
                        timer_q      <= BLOCK_TICKS;
                    end
                    else if (!pickup)
                        state_q <= (shot_q == 4'h0) ? S_IDLE : S_RECLAIM;
                end
                S_OPENING:
                begin
                    if (!trip || cb_op_s)
                    begin
                        state_q <= S_DEAD;                          // [RULE7]
                        timer_q <= cyc_dead;
                    end
                end
                S_DEAD:
                begin
                    if (timer_done)
                    begin
                        if (sync_ok_s)
                        begin
                            state_q     <= S_RECLAIM;               // [RULE8]
                            close_cmd_o <= 1'b1;
                            timer_q     <= reclaim_q;               // [RULE9]
                        end
                        else
                        begin
                            state_q <= S_EXTEND;                    // [RULE12]
                            timer_q <= extlim_q;
                        end
                    end
                end
                S_EXTEND:
                begin
                    if (sync_ok_s)
                    begin
                        state_q     <= S_RECLAIM;                   // [RULE8]
                        close_cmd_o <= 1'b1;
                        timer_q     <= reclaim_q;
                    end
                    else if (timer_done)
                    begin
                        state_q   <= S_BLOCKED;                     // [RULE13]
                        blocked_o <= 1'b1;
                        timer_q   <= BLOCK_TICKS;
                    end
                end
                S_RECLAIM:
                begin
                    if (trip)
                    begin
                        close_cmd_o <= 1'b0;
                        if (more && !blk2_s)
                        begin
                            state_q <= S_OPENING;                   // [RULE6] [RULE9]
                            shot_q  <= shot_q + 4'h1;
                            timer_q <= {TW{1'b0}};
                        end
                        else
                        begin
                            state_q      <= S_BLOCKED;              // [RULE1] [RULE11]
                            final_trip_o <= 1'b1;
                            blocked_o    <= 1'b1;
                            timer_q      <= BLOCK_TICKS;
                        end
                    end
                    else if (pickup && !first)
                    begin
                        state_q <= S_ACTION;                        // [RULE16]
                        timer_q <= cyc_act;
                    end
                    else if (timer_done)
                    begin
                        state_q   <= S_IDLE;                        // [RULE10]
                        shot_q    <= 4'h0;
                        success_q <= 1'b1;
                    end
                end
                S_BLOCKED:
                begin
                    close_cmd_o <= 1'b0;
                    if (timer_done)
                    begin
                        if (other_block)
                            timer_q <= BLOCK_TICKS;                 // [RULE14]
                        else
                        begin
                            state_q      <= S_IDLE;                 // [RULE19]
                            shot_q       <= 4'h0;
                            final_trip_o <= 1'b0;
                            blocked_o    <= 1'b0;
                        end
                    end
                end
                default:
                begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // wishbone slave: one wait cycle, ack for one cycle
    // ------------------------------------------------------------------
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr  = req && wb_we_i;

    wire [31:0] status_word = {20'h00000, success_q, final_trip_o, blocked_o, close_cmd_o,
                               shot_q, 1'b0, state_q};
    reg  [31:0] rd_mux;

    always @*
    begin
        case (wb_adr_i)
            `ARS_OFF_CTRL:    rd_mux = {24'h000000, ctrl_q};
            `ARS_OFF_DEAD1:   rd_mux = {16'h0000, dead1_q};
            `ARS_OFF_DEAD2:   rd_mux = {16'h0000, dead2_q};
            `ARS_OFF_ACT1:    rd_mux = {16'h0000, act1_q};
            `ARS_OFF_ACT2:    rd_mux = {16'h0000, act2_q};
            `ARS_OFF_RECLAIM: rd_mux = {16'h0000, reclaim_q};
            `ARS_OFF_EXTLIM:  rd_mux = {16'h0000, extlim_q};
            `ARS_OFF_STATUS:  rd_mux = status_word;
            default:          rd_mux = 32'h00000000;
        endcase
    end

    // per-lane write of a 16-bit timer field
    function [15:0] lanes16;
        input [15:0] old;
        input [31:0] dat;
        input [3:0]  sel;
        begin
            lanes16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
        end
    endfunction

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= 32'h00000000;
            ctrl_q    <= `ARS_RST_CTRL;
            dead1_q   <= `ARS_RST_DEAD1;
            dead2_q   <= `ARS_RST_DEAD2;
            act1_q    <= `ARS_RST_ACT1;
            act2_q    <= `ARS_RST_ACT2;
            reclaim_q <= `ARS_RST_RECLAIM;
            extlim_q  <= `ARS_RST_EXTLIM;
        end
        else
        begin
            wb_ack_o <= req;
            if (req)
                wb_dat_o <= rd_mux;
            if (wr)
            begin
                case (wb_adr_i)
                    `ARS_OFF_CTRL:    if (wb_sel_i[0]) ctrl_q <= wb_dat_i[7:0];
                    `ARS_OFF_DEAD1:   dead1_q   <= lanes16(dead1_q, wb_dat_i, wb_sel_i);
                    `ARS_OFF_DEAD2:   dead2_q   <= lanes16(dead2_q, wb_dat_i, wb_sel_i);
                    `ARS_OFF_ACT1:    act1_q    <= lanes16(act1_q, wb_dat_i, wb_sel_i);
                    `ARS_OFF_ACT2:    act2_q    <= lanes16(act2_q, wb_dat_i, wb_sel_i);
                    `ARS_OFF_RECLAIM: reclaim_q <= lanes16(reclaim_q, wb_dat_i, wb_sel_i);
                    `ARS_OFF_EXTLIM:  extlim_q  <= lanes16(extlim_q, wb_dat_i, wb_sel_i);
                    default:          ctrl_q    <= ctrl_q;
                endcase
            end
        end
    end
endmodule

// file: test/ars_seq_chk.sv
// concurrent checks on the reclose sequencer ports
module ars_seq_chk #(
    parameter integer TICK_DIV = 100000 // cycles per timer tick
) (
    input wire logic clk,          // system clock
    input wire logic rstn,         // reset, active low
    input wire logic wb_cyc_i,     // bus cycle
    input wire logic wb_stb_i,     // bus strobe
    input wire logic wb_ack_o,     // bus acknowledge
    input wire logic close_cmd_o,  // close command
    input wire logic final_trip_o, // final trip
    input wire logic blocked_o     // dynamic blocking
);
    timeunit 1ns;
    timeprecision 1ps;
    // one tick of expiry slack
    localparam int BLK_MIN = 499 * TICK_DIV - 3;
    logic [31:0] blk_cnt_q;
    always @(posedge clk)
    begin
        if (!rstn || !blocked_o) blk_cnt_q <= 32'h0;
        else if (blk_cnt_q != 32'hFFFFFFFF) blk_cnt_q <= blk_cnt_q + 32'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    ack_resp_a: assert property (s_req |=> wb_ack_o) else $error("request not acked");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
    rst_quiet_a: assert property ($rose(rstn) |-> !close_cmd_o && !blocked_o && !final_trip_o)
        else $error("outputs active at reset");
    blk_close_a: assert property (blocked_o && $past(blocked_o) |-> !close_cmd_o)
        else $error("close while blocked");
    close_free_a: assert property ($rose(close_cmd_o) |-> !blocked_o)
        else $error("close in blocking");
    final_blk_a: assert property ($rose(final_trip_o) |-> ##[0:1] blocked_o)
        else $error("final trip without blocking");
    final_end_a: assert property (final_trip_o |-> blocked_o)
        else $error("final trip outside blocking");
    blk_len_a: assert property ($fell(blocked_o) |-> blk_cnt_q >= BLK_MIN)
        else $error("blocking too short");
endmodule
bind ars_seq ars_seq_chk #(.TICK_DIV(TICK_DIV)) u_ars_chk (.clk(clk), .rstn(rstn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .close_cmd_o(close_cmd_o),
    .final_trip_o(final_trip_o), .blocked_o(blocked_o));

// file: test/ars_cb_model.sv
// breaker model with aux contacts and variable operating time
module ars_cb_model (
    input  wire logic       clk,        // system clock
    input  wire logic       trip,       // trip coil
    input  wire logic       close_cmd,  // close coil
    input  wire logic       man_close,  // manual close
    input  wire logic       stuck_open, // keeps breaker open
    input  wire logic [3:0] dly,        // operating time in cycles
    output logic            aux_closed, // contact: closed
    output logic            aux_open    // contact: open
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q = 4'h0;
    logic       pos_q = 1'b1;
    logic       tgt;
    // trip-free: trip wins over close
    assign tgt = (trip || stuck_open) ? 1'b0 : ((close_cmd || man_close) ? 1'b1 : pos_q);
    always @(posedge clk)
    begin
        if (tgt == pos_q) cnt_q <= 4'h0;
        else if (cnt_q >= dly) pos_q <= tgt;
        else cnt_q <= cnt_q + 4'h1;
    end
    assign aux_closed = pos_q;
    assign aux_open = !pos_q;
endmodule

// file: test/tb_top.sv
// self-checking bench for the reclose sequencer
`include "ars_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam integer TD = 10;
    logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, close, fin, blk;
    logic tr = 1'b0, etr = 1'b0, epu = 1'b0, pu = 1'b0, b1 = 1'b0, b2 = 1'b0, sync = 1'b1;
    logic stuck = 1'b0, man = 1'b0, aux_c, aux_o;
    logic [3:0] sel = 4'hF, dly = 4'h2;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, dout, q;
    int err_count = 0, total_checks = 0, tmo = 0, t0 = 0;
    always #5 clk = ~clk;
    ars_seq #(.TICK_DIV(TD)) i_ars_seq (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout),
        .wb_ack_o(ack), .int_pickup_in(pu), .int_trip_in(tr), .external_general_pickup_in(epu),
        .external_trip_for_reclose_in(etr), .cb_aux_closed_in(aux_c), .cb_aux_open_in(aux_o),
        .block_cycle1_in(b1), .block_cycle2_in(b2), .sync_release_in(sync),
        .close_cmd_o(close), .final_trip_o(fin), .blocked_o(blk));
    ars_cb_model i_ars_cb_model (.clk(clk), .trip(tr || etr), .close_cmd(close), .man_close(man),
        .stuck_open(stuck), .dly(dly), .aux_closed(aux_c), .aux_open(aux_o));
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        tmo <= tmo + 1;
        if (tmo == 30000)
        begin
            err_count++;
            print_verdict();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = dout;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q & m);
    endtask
    function logic pick(input int s);
        return (s == 0) ? close : ((s == 1) ? blk : aux_c);
    endfunction
    task wt(input int s, input logic v);
        while (pick(s) !== v) @(posedge clk);
    endtask
    // trip held until the breaker opens, then dropped
    task fault(input logic ext);
        @(posedge clk);
        dly <= 4'($urandom_range(1, 6));
        if (ext) etr <= 1'b1;
        else tr <= 1'b1;
        while (aux_o !== 1'b1) @(posedge clk);
        repeat ($urandom_range(1, 4)) @(posedge clk);
        tr <= 1'b0; etr <= 1'b0; t0 = tmo;
    endtask
    task reclose(input string nm);
        @(posedge clk);
        man <= 1'b1;
        @(posedge clk);
        wt(2, 1'b1);
        man <= 1'b0;
        $display("test %s done", nm);
    endtask
    initial
    begin
        void'($urandom(32'h785730f2));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rd(`ARS_OFF_CTRL, 32'hFF, {24'h0, `ARS_RST_CTRL}, "ctrl");
        rd(`ARS_OFF_DEAD1, 32'hFFFF, {16'h0, `ARS_RST_DEAD1}, "dead1");
        rd(`ARS_OFF_STATUS, 32'h7FF, 32'h0, "status");
        bus(1'b1, 8'h40, 32'hFFFF);
        rd(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
        bus(1'b1, `ARS_OFF_DEAD1, 32'h3);
        bus(1'b1, `ARS_OFF_DEAD2, 32'h4);
        bus(1'b1, `ARS_OFF_RECLAIM, 32'h8);
        bus(1'b1, `ARS_OFF_EXTLIM, 32'h8);
        rd(`ARS_OFF_DEAD1, 32'hFFFF, 32'h3, "dead1 rw");
        fault(1'b0);
        wt(0, 1'b1);
        chk("dead1 time", 32'h1, 32'(tmo - t0 >= 2 * TD && tmo - t0 <= 4 * TD + 6));
        rd(`ARS_OFF_STATUS, 32'hFF, 32'h15, "shot one");
        repeat (12 * TD) @(posedge clk);
        rd(`ARS_OFF_STATUS, 32'h807, 32'h800, "success");
        reclose("single shot");
        stuck <= 1'b1;
        wt(2, 1'b0);
        repeat (4) @(posedge clk);
        fault(1'b0);
        repeat (8 * TD) @(posedge clk);
        chk("open start", 32'h0, 32'(close));
        stuck <= 1'b0;
        reclose("open breaker");
        bus(1'b1, `ARS_OFF_CTRL, 32'h21);
        fault(1'b0);
        wt(2, 1'b1);
        fault(1'b0);
        wt(0, 1'b1);
        chk("dead2 time", 32'h1, 32'(tmo - t0 >= 3 * TD && tmo - t0 <= 5 * TD + 6));
        rd(`ARS_OFF_STATUS, 32'hFF, 32'h25, "shot two");
        wt(2, 1'b1);
        fault(1'b0);
        wt(1, 1'b1);
        chk("final", 32'h1, 32'(fin));
        rd(`ARS_OFF_STATUS, 32'h407, 32'h406, "blocked");
        wt(1, 1'b0);
        rd(`ARS_OFF_STATUS, 32'h7, 32'h0, "idle again");
        reclose("multi shot");
        bus(1'b1, `ARS_OFF_CTRL, 32'h11);
        sync <= 1'b0;
        fault(1'b0);
        repeat (5 * TD) @(posedge clk);
        rd(`ARS_OFF_STATUS, 32'h107, 32'h4, "extend");
        wt(1, 1'b1);
        chk("ext final", 32'h0, 32'(fin));
        sync <= 1'b1;
        wt(1, 1'b0);
        rd(`ARS_OFF_STATUS, 32'h7, 32'h0, "ext idle");
        reclose("extension");
        b1 <= 1'b1;
        fault(1'b0);
        wt(1, 1'b1);
        chk("cycle1 block", 32'h1, {31'h0, fin & !close});
        b1 <= 1'b0;
        wt(1, 1'b0);
        reclose("cycle block");
        bus(1'b1, `ARS_OFF_CTRL, 32'h17);
        fault(1'b1);
        wt(0, 1'b1);
        chk("external", 32'h1, 32'(close));
        reclose("external");
        print_verdict();
    end
endmodule
